// [rtl/reset_cause_pkg.sv]
// Constants shared by the reset cause recorder
package reset_cause_pkg;

	// Register byte offsets
	localparam logic [7:0] CAUSE_OFF    = 8'h00;
	localparam logic [7:0] STACK_OFF    = 8'h04;
	localparam logic [7:0] CONFIG_OFF   = 8'h08;
	localparam logic [7:0] RESTART_OFF  = 8'h0C;
	localparam logic [7:0] EV_STAT_OFF  = 8'h10;
	localparam logic [7:0] EV_MASK_OFF  = 8'h14;
	localparam logic [7:0] SCRATCH_OFF  = 8'h18;

	// Cause register fields
	localparam int BROWNOUT_BIT  = 0;
	localparam int POWERON_BIT   = 1;
	localparam int POWERDOWN_BIT = 2;
	localparam int TIMEOUT_BIT   = 3;
	localparam int RESET_INS_BIT = 4;
	localparam int SOFT_BOR_BIT  = 6;
	localparam logic [7:0] CAUSE_WMASK = 8'h5F;

	// Stack register fields
	localparam int STACK_UNF_BIT = 6;
	localparam int STACK_FUL_BIT = 7;
	localparam logic [7:0] STACK_WMASK = 8'hC0;

	// Configuration register fields
	localparam int STACK_RST_EN_BIT = 0;
	localparam int BOR_MODE_LSB     = 1;
	localparam int GIE_LOW_BIT      = 3;
	localparam int GIE_HIGH_BIT     = 4;
	localparam logic [7:0] CONFIG_WMASK = 8'h1F;

	// Event status bits
	localparam int EV_BROWNOUT  = 0;
	localparam int EV_RESET_INS = 1;
	localparam int EV_PIN_CLEAR = 2;
	localparam int EV_WDT_RESET = 3;
	localparam int EV_WDT_WAKE  = 4;
	localparam int EV_STACK_FUL = 5;
	localparam int EV_STACK_UNF = 6;
	localparam int EV_INT_WAKE  = 7;

	// Reset values
	localparam logic [7:0]  CAUSE_POR_VALUE  = 8'h5C;
	localparam logic [7:0]  STACK_POR_VALUE  = 8'h00;
	localparam logic [7:0]  CONFIG_POR_VALUE = 8'h00;
	localparam logic [7:0]  EV_STATUS_POR_VALUE = 8'h00;
	localparam logic [7:0]  EV_MASK_POR_VALUE   = 8'h00;
	localparam logic [1:0]  PIN_SYNC_POR_VALUE  = 2'h3;
	localparam logic [31:0] SCRATCH_POR_VALUE = 32'h00000000;

	// Brown-out mode that lets software own the brown-out enable
	localparam logic [1:0] BOR_SOFT_MODE = 2'h1;

	// Power states on the core's mode input
	localparam logic [1:0] PM_FULL  = 2'h0;
	localparam logic [1:0] PM_RUN   = 2'h1;
	localparam logic [1:0] PM_IDLE  = 2'h2;
	localparam logic [1:0] PM_SLEEP = 2'h3;

	// Restart addresses and the PC step for wakes
	localparam logic [20:0] RESET_VECTOR    = 21'h000000;
	localparam logic [20:0] HIGH_INT_VECTOR = 21'h000008;
	localparam logic [20:0] LOW_INT_VECTOR  = 21'h000018;
	localparam logic [20:0] WAKE_PC_STEP    = 21'h000002;

	typedef enum logic [3:0] {
		ev_none,
		ev_brownout,
		ev_clear_run,
		ev_clear_idle,
		ev_clear_full,
		ev_wdt_reset,
		ev_wdt_wake,
		ev_reset_ins,
		ev_stack_ful,
		ev_stack_unf_reset,
		ev_stack_unf_error,
		ev_int_wake
	} event_kind_type;

endpackage : reset_cause_pkg

// [rtl/reset_cause_status_logic.sv]
// Reset cause flags, restart address selection and APB register file
// Notes on behaviour
// (RL1) Power-on: address zero, flags to fixed values
// (RL2) Reset instruction clears its flag only
// (RL3) Brown-out sets three flags, clears its own
// (RL4) Master clear in run: set timeout
// (RL5) Master clear idle/sleep: timeout set, powerdown cleared
// (RL6) Watchdog reset in full/run clears timeout
// (RL7) Master clear full power: flags unchanged
// (RL8) Enabled stack full resets, sets full flag
// (RL9) Enabled underflow resets, sets underflow flag
// (RL10) Disabled underflow sets flag, no reset
// (RL11) Watchdog wake: PC+2, clear timeout, powerdown
// (RL12) Interrupt wake: PC+2, clear powerdown
// (RL13) Enabled interrupt wake jumps to vector
// (RL14) Brown-out enable kept only in soft mode
// (RL15) Watchdog wake keeps register contents
// (RL16) Plain registers survive all non-power-on resets
// (RL17) Software reads, rewrites flags after restart
//
// Decided for this implementation: the address map and the APB register port.
`timescale 1ns/1ps

module reset_cause_status_logic #(
	parameter int PC_W = 21
) (
	// Clock and power-on reset
	input  wire logic            pclk,
	input  wire logic            presetn,
	// APB slave
	input  wire logic            psel,
	input  wire logic            penable,
	input  wire logic            pwrite,
	input  wire logic [7:0]      paddr,
	input  wire logic [31:0]     pwdata,
	output logic                 pready,
	output logic                 pslverr,
	output logic [31:0]          prdata,
	// Reset and wake sources
	input  wire logic            master_clear_input_n,
	input  wire logic            brownout_event,
	input  wire logic            reset_instruction_event,
	input  wire logic            watchdog_timer_event,
	input  wire logic            stack_full_event,
	input  wire logic            stack_underflow_event,
	input  wire logic            interrupt_wake_event,
	input  wire logic            interrupt_high_priority,
	input  wire logic [1:0]      power_mode,
	input  wire logic [PC_W-1:0] current_pc,
	// Core restart control
	output logic                 restart_pulse,
	output logic                 core_reset_pulse,
	output logic [PC_W-1:0]      restart_addr,
	output logic                 soft_brownout_enable,
	// Interrupt
	output logic                 irq
);

	typedef struct packed {
		logic [7:0]      cause;
		logic [7:0]      stack;
		logic [7:0]      config_bits;
		logic [7:0]      ev_status;
		logic [7:0]      ev_mask;
		logic [31:0]     scratch;
		logic [PC_W-1:0] restart_addr;
		logic            restart_pulse;
		logic            core_reset;
		logic            irq;
		logic [31:0]     prdata;
		logic [1:0]      clear_sync;
		logic            clear_prev;
	} state_type;

	state_type                      state_reg;
	state_type                      state_next;
	reset_cause_pkg::event_kind_type kind;
	logic                           clear_event;
	logic                           wr_en;
	logic                           stack_rst_en;
	logic [1:0]                     bor_mode;

	// Brown-out enable survives a reset only in software mode
	function automatic logic kept_soft_enable(input logic [7:0] cause, input logic [1:0] mode);
		kept_soft_enable = (mode == reset_cause_pkg::BOR_SOFT_MODE)
			&& cause[reset_cause_pkg::SOFT_BOR_BIT]; // RL14
	endfunction : kept_soft_enable

	function automatic logic addr_mapped(input logic [7:0] a);
		case (a)
			reset_cause_pkg::CAUSE_OFF,
			reset_cause_pkg::STACK_OFF,
			reset_cause_pkg::CONFIG_OFF,
			reset_cause_pkg::RESTART_OFF,
			reset_cause_pkg::EV_STAT_OFF,
			reset_cause_pkg::EV_MASK_OFF,
			reset_cause_pkg::SCRATCH_OFF: addr_mapped = 1'b1;
			default: addr_mapped = 1'b0;
		endcase
	endfunction : addr_mapped

	// Zero wait states; read data is latched in the setup cycle
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !addr_mapped(paddr);
	assign wr_en   = psel && penable && pwrite && addr_mapped(paddr);

	assign stack_rst_en = state_reg.config_bits[reset_cause_pkg::STACK_RST_EN_BIT];
	assign bor_mode     = state_reg.config_bits[reset_cause_pkg::BOR_MODE_LSB +: 2];
	assign clear_event  = state_reg.clear_prev && !state_reg.clear_sync[1];

	// One source per cycle; brown-out dominates since supply is suspect
	always_comb
	begin
		kind = reset_cause_pkg::ev_none;
		if (brownout_event)
			kind = reset_cause_pkg::ev_brownout;
		else if (clear_event)
		begin
			case (power_mode)
				reset_cause_pkg::PM_RUN:  kind = reset_cause_pkg::ev_clear_run;
				reset_cause_pkg::PM_FULL: kind = reset_cause_pkg::ev_clear_full;
				default:                  kind = reset_cause_pkg::ev_clear_idle;
			endcase
		end
		else if (watchdog_timer_event)
		begin
			if (power_mode == reset_cause_pkg::PM_IDLE
					|| power_mode == reset_cause_pkg::PM_SLEEP)
				kind = reset_cause_pkg::ev_wdt_wake;
			else
				kind = reset_cause_pkg::ev_wdt_reset;
		end
		else if (reset_instruction_event)
			kind = reset_cause_pkg::ev_reset_ins;
		else if (stack_full_event && stack_rst_en)
			kind = reset_cause_pkg::ev_stack_ful;
		else if (stack_underflow_event)
		begin
			if (stack_rst_en)
				kind = reset_cause_pkg::ev_stack_unf_reset;
			else
				kind = reset_cause_pkg::ev_stack_unf_error;
		end
		else if (interrupt_wake_event && power_mode != reset_cause_pkg::PM_FULL)
			kind = reset_cause_pkg::ev_int_wake;
	end

	always_comb
	begin
		state_next = state_reg;
		state_next.restart_pulse = 1'b0;
		state_next.core_reset    = 1'b0;

		// Pin passes two flops before the edge detector
		state_next.clear_sync = {state_reg.clear_sync[0], master_clear_input_n};
		state_next.clear_prev = state_reg.clear_sync[1];

		// Software write first, so a same-cycle hardware event overrides it
		if (wr_en)
		begin
			case (paddr)
				reset_cause_pkg::CAUSE_OFF:
					state_next.cause = pwdata[7:0] & reset_cause_pkg::CAUSE_WMASK; // RL17
				reset_cause_pkg::STACK_OFF:
					state_next.stack = pwdata[7:0] & reset_cause_pkg::STACK_WMASK; // RL17
				reset_cause_pkg::CONFIG_OFF:
					state_next.config_bits = pwdata[7:0] & reset_cause_pkg::CONFIG_WMASK;
				reset_cause_pkg::EV_STAT_OFF:
					state_next.ev_status = state_reg.ev_status & ~pwdata[7:0];
				reset_cause_pkg::EV_MASK_OFF:
					state_next.ev_mask = pwdata[7:0];
				reset_cause_pkg::SCRATCH_OFF:
					state_next.scratch = pwdata; // RL16
				default:
					state_next.scratch = state_reg.scratch;
			endcase
		end

		case (kind)
			reset_cause_pkg::ev_brownout:
			begin
				state_next.cause[reset_cause_pkg::RESET_INS_BIT] = 1'b1; // RL3
				state_next.cause[reset_cause_pkg::TIMEOUT_BIT]   = 1'b1; // RL3
				state_next.cause[reset_cause_pkg::POWERDOWN_BIT] = 1'b1; // RL3
				state_next.cause[reset_cause_pkg::BROWNOUT_BIT]  = 1'b0; // RL3
				state_next.ev_status[reset_cause_pkg::EV_BROWNOUT] = 1'b1;
			end
			reset_cause_pkg::ev_reset_ins:
			begin
				state_next.cause[reset_cause_pkg::RESET_INS_BIT] = 1'b0; // RL2
				state_next.ev_status[reset_cause_pkg::EV_RESET_INS] = 1'b1;
			end
			reset_cause_pkg::ev_clear_run:
			begin
				state_next.cause[reset_cause_pkg::TIMEOUT_BIT] = 1'b1; // RL4
				state_next.ev_status[reset_cause_pkg::EV_PIN_CLEAR] = 1'b1;
			end
			reset_cause_pkg::ev_clear_idle:
			begin
				state_next.cause[reset_cause_pkg::TIMEOUT_BIT]   = 1'b1; // RL5
				state_next.cause[reset_cause_pkg::POWERDOWN_BIT] = 1'b0; // RL5
				state_next.ev_status[reset_cause_pkg::EV_PIN_CLEAR] = 1'b1;
			end
			reset_cause_pkg::ev_clear_full:
				state_next.ev_status[reset_cause_pkg::EV_PIN_CLEAR] = 1'b1; // RL7
			reset_cause_pkg::ev_wdt_reset:
			begin
				state_next.cause[reset_cause_pkg::TIMEOUT_BIT] = 1'b0; // RL6
				state_next.ev_status[reset_cause_pkg::EV_WDT_RESET] = 1'b1;
			end
			reset_cause_pkg::ev_wdt_wake:
			begin
				state_next.cause[reset_cause_pkg::TIMEOUT_BIT]   = 1'b0; // RL11
				state_next.cause[reset_cause_pkg::POWERDOWN_BIT] = 1'b0; // RL11
				state_next.ev_status[reset_cause_pkg::EV_WDT_WAKE] = 1'b1;
			end
			reset_cause_pkg::ev_stack_ful:
			begin
				state_next.stack[reset_cause_pkg::STACK_FUL_BIT] = 1'b1; // RL8
				state_next.ev_status[reset_cause_pkg::EV_STACK_FUL] = 1'b1;
			end
			reset_cause_pkg::ev_stack_unf_reset,
			reset_cause_pkg::ev_stack_unf_error:
			begin
				state_next.stack[reset_cause_pkg::STACK_UNF_BIT] = 1'b1; // RL9 RL10
				state_next.ev_status[reset_cause_pkg::EV_STACK_UNF] = 1'b1;
			end
			reset_cause_pkg::ev_int_wake:
			begin
				state_next.cause[reset_cause_pkg::POWERDOWN_BIT] = 1'b0; // RL12
				state_next.ev_status[reset_cause_pkg::EV_INT_WAKE] = 1'b1;
			end
			default:
				state_next.restart_pulse = 1'b0;
		endcase

		// Restart address; wakes leave everything else intact
		case (kind)
			reset_cause_pkg::ev_none,
			reset_cause_pkg::ev_stack_unf_error:
				state_next.restart_addr = state_reg.restart_addr; // RL10
			reset_cause_pkg::ev_wdt_wake:
			begin
				state_next.restart_pulse = 1'b1;
				state_next.restart_addr  = current_pc
					+ reset_cause_pkg::WAKE_PC_STEP[PC_W-1:0]; // RL11 RL15
			end
			reset_cause_pkg::ev_int_wake:
			begin
				state_next.restart_pulse = 1'b1;
				if (interrupt_high_priority
						&& state_reg.config_bits[reset_cause_pkg::GIE_HIGH_BIT])
					state_next.restart_addr =
						reset_cause_pkg::HIGH_INT_VECTOR[PC_W-1:0]; // RL13
				else if (!interrupt_high_priority
						&& state_reg.config_bits[reset_cause_pkg::GIE_LOW_BIT])
					state_next.restart_addr =
						reset_cause_pkg::LOW_INT_VECTOR[PC_W-1:0]; // RL13
				else
					state_next.restart_addr = current_pc
						+ reset_cause_pkg::WAKE_PC_STEP[PC_W-1:0]; // RL12
			end
			default:
			begin
				// A real reset of the core
				state_next.restart_pulse = 1'b1;
				state_next.core_reset    = 1'b1;
				state_next.restart_addr  = reset_cause_pkg::RESET_VECTOR[PC_W-1:0];
				state_next.cause[reset_cause_pkg::SOFT_BOR_BIT] =
					kept_soft_enable(state_reg.cause, bor_mode); // RL14
			end
		endcase

		state_next.irq = |(state_next.ev_status & state_next.ev_mask);

		// Read data captured in the setup phase
		if (psel && !penable)
		begin
			case (paddr)
				reset_cause_pkg::CAUSE_OFF:   state_next.prdata = {24'h000000, state_reg.cause};
				reset_cause_pkg::STACK_OFF:   state_next.prdata = {24'h000000, state_reg.stack};
				reset_cause_pkg::CONFIG_OFF:
					state_next.prdata = {24'h000000, state_reg.config_bits};
				reset_cause_pkg::RESTART_OFF:
					state_next.prdata = {{(32-PC_W){1'b0}}, state_reg.restart_addr};
				reset_cause_pkg::EV_STAT_OFF:
					state_next.prdata = {24'h000000, state_reg.ev_status};
				reset_cause_pkg::EV_MASK_OFF:
					state_next.prdata = {24'h000000, state_reg.ev_mask};
				reset_cause_pkg::SCRATCH_OFF: state_next.prdata = state_reg.scratch;
				default:                      state_next.prdata = 32'h00000000;
			endcase
		end
	end

	// Asynchronous reset is the power-on event
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_reg.cause        <= reset_cause_pkg::CAUSE_POR_VALUE; // RL1 RL14
			state_reg.stack        <= reset_cause_pkg::STACK_POR_VALUE; // RL1
			state_reg.config_bits  <= reset_cause_pkg::CONFIG_POR_VALUE;
			state_reg.ev_status    <= reset_cause_pkg::EV_STATUS_POR_VALUE;
			state_reg.ev_mask      <= reset_cause_pkg::EV_MASK_POR_VALUE;
			state_reg.scratch      <= reset_cause_pkg::SCRATCH_POR_VALUE; // RL16
			state_reg.restart_addr <= reset_cause_pkg::RESET_VECTOR[PC_W-1:0]; // RL1
			state_reg.restart_pulse <= 1'b0;
			state_reg.core_reset   <= 1'b0;
			state_reg.irq          <= 1'b0;
			state_reg.prdata       <= 32'h00000000;
			state_reg.clear_sync   <= reset_cause_pkg::PIN_SYNC_POR_VALUE;
			state_reg.clear_prev   <= 1'b1;
		end
		else
			state_reg <= state_next;
	end

	assign prdata               = state_reg.prdata;
	assign restart_pulse        = state_reg.restart_pulse;
	assign core_reset_pulse     = state_reg.core_reset;
	assign restart_addr         = state_reg.restart_addr;
	assign soft_brownout_enable = state_reg.cause[reset_cause_pkg::SOFT_BOR_BIT];
	assign irq                  = state_reg.irq;

endmodule : reset_cause_status_logic

// [testbench/reset_cause_status_properties.sv]
// Port level checks for the reset cause recorder
`timescale 1ns/1ps
module reset_cause_status_properties #(
	parameter int PC_W = 21
) (
	// Clock and reset
	input wire logic            pclk,
	input wire logic            presetn,
	// Sources
	input wire logic            master_clear_input_n,
	input wire logic            brownout_event,
	input wire logic            reset_instruction_event,
	input wire logic            watchdog_timer_event,
	input wire logic            stack_full_event,
	input wire logic            stack_underflow_event,
	input wire logic            interrupt_wake_event,
	input wire logic            interrupt_high_priority,
	input wire logic [1:0]      power_mode,
	input wire logic [PC_W-1:0] current_pc,
	// Restart control
	input wire logic            restart_pulse,
	input wire logic            core_reset_pulse,
	input wire logic [PC_W-1:0] restart_addr
);
	logic [4:0] hi_ev;
	assign hi_ev = {brownout_event, reset_instruction_event, watchdog_timer_event,
		stack_full_event, stack_underflow_event};
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence real_restart;
		restart_pulse && core_reset_pulse && restart_addr == '0;
	endsequence
	sequence wake_restart;
		restart_pulse && !core_reset_pulse;
	endsequence
	chk_brownout_restart: assert property (brownout_event |=> real_restart)
		else $error("brownout restart wrong");
	chk_instr_restart: assert property (reset_instruction_event
		&& !watchdog_timer_event |=> real_restart)
		else $error("reset instruction restart wrong");
	chk_wdog_reset: assert property (watchdog_timer_event && !power_mode[1]
		|=> real_restart)
		else $error("watchdog reset wrong");
	chk_wdog_wake: assert property (watchdog_timer_event && power_mode[1]
		&& !brownout_event |=> wake_restart ##0 restart_addr == PC_W'($past(current_pc) + 2))
		else $error("watchdog wake address wrong");
	chk_int_wake: assert property (interrupt_wake_event && power_mode != 2'h0
		&& hi_ev == '0 |=> wake_restart ##0 (restart_addr == PC_W'($past(current_pc) + 2)
		|| restart_addr == ($past(interrupt_high_priority) ? PC_W'(8) : PC_W'(24))))
		else $error("interrupt wake address wrong");
	chk_core_zero: assert property (core_reset_pulse |-> restart_pulse && restart_addr == '0)
		else $error("core reset not at zero");
	chk_pin_restart: assert property ($fell(master_clear_input_n) |-> ##[1:4] real_restart)
		else $error("master clear restart missing");
	// Only for isolated causes: back to back events may pulse twice
	chk_single_pulse: assert property ($rose(restart_pulse) && hi_ev == '0
		&& !interrupt_wake_event && master_clear_input_n |=> !restart_pulse)
		else $error("restart pulse too long");
endmodule : reset_cause_status_properties

bind reset_cause_status_logic reset_cause_status_properties #(.PC_W(PC_W)) props_i (
	.pclk(pclk), .presetn(presetn), .master_clear_input_n(master_clear_input_n),
	.brownout_event(brownout_event), .reset_instruction_event(reset_instruction_event),
	.watchdog_timer_event(watchdog_timer_event), .stack_full_event(stack_full_event),
	.stack_underflow_event(stack_underflow_event), .interrupt_wake_event(interrupt_wake_event),
	.interrupt_high_priority(interrupt_high_priority),
	.power_mode(power_mode), .current_pc(current_pc), .restart_pulse(restart_pulse),
	.core_reset_pulse(core_reset_pulse), .restart_addr(restart_addr));

// [testbench/tb_top.sv]
// Self-checking bench for the reset cause recorder
`timescale 1ns/1ps
module tb_top;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rd_err;
	logic [7:0]  paddr, exp_cause, exp_stack, exp_cfg, exp_stat, exp_mask;
	logic [31:0] pwdata, prdata, rd_data;
	logic        mc_pin_n, int_hi, rp, crp, sbe, irq;
	logic [5:0]  ev;
	logic [1:0]  pm;
	logic [20:0] pc, raddr, exp_addr;
	logic [15:0] rnd;
	int          n_fail, checks_done, i, k;

	reset_cause_status_logic reset_cause_status_logic_i (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
		.master_clear_input_n(mc_pin_n), .brownout_event(ev[0]),
		.reset_instruction_event(ev[1]), .watchdog_timer_event(ev[2]),
		.stack_full_event(ev[3]), .stack_underflow_event(ev[4]), .interrupt_wake_event(ev[5]),
		.interrupt_high_priority(int_hi), .power_mode(pm), .current_pc(pc),
		.restart_pulse(rp), .core_reset_pulse(crp), .restart_addr(raddr),
		.soft_brownout_enable(sbe), .irq(irq));

	task automatic test_done;
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : test_done

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (exp !== got)
		begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'h1 && n < 20);
		rd_data = prdata;
		rd_err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		if (n >= 20)
		begin
			n_fail++;
			test_done();
		end
	endtask : apb

	task automatic rd_check(input string what, input logic [7:0] a, input logic [31:0] exp);
		apb(1'h0, a, 32'h0);
		check(what, exp, rd_data);
	endtask : rd_check

	function automatic logic [7:0] stat_bit(input int k);
		case (k)
			0: return 8'h01;
			1: return 8'h02;
			2: return pm[1] ? 8'h10 : 8'h08;
			3: return exp_cfg[0] ? 8'h20 : 8'h00;
			4: return 8'h40;
			5: return (pm != 2'h0) ? 8'h80 : 8'h00;
			default: return 8'h04;
		endcase
	endfunction : stat_bit

	function automatic logic [7:0] next_cause(input int k, input logic [7:0] c, input logic r);
		case (k)
			0: c = (c | 8'h1C) & 8'hFE;
			1: c[4] = 1'h0;
			2: c = c & (pm[1] ? 8'hF3 : 8'hF7);
			5: c[2] = c[2] & (pm == 2'h0);
			6: c = (c | ((pm != 2'h0) ? 8'h08 : 8'h00)) & (pm[1] ? 8'hFB : 8'hFF);
			default: ;
		endcase
		// Soft brown-out enable survives a real reset only in software mode
		if (r)
			c[6] = c[6] & (exp_cfg[2:1] == 2'h1);
		return c;
	endfunction : next_cause

	task automatic fire(input int k);
		logic r, c;
		int n;
		@(posedge pclk);
		r = stat_bit(k) != 8'h00 && !(k == 4 && !exp_cfg[0]);
		c = r && k != 5 && !(k == 2 && pm[1]);
		exp_cause = next_cause(k, exp_cause, c);
		exp_stack |= (k == 3 && exp_cfg[0]) ? 8'h80 : ((k == 4) ? 8'h40 : 8'h00);
		exp_stat |= stat_bit(k);
		if (r)
			exp_addr = c ? 21'h0 : (k == 5 && int_hi && exp_cfg[4]) ? 21'h000008 :
				(k == 5 && !int_hi && exp_cfg[3]) ? 21'h000018 : pc + 21'h000002;
		if (k == 6)
			mc_pin_n <= 1'h0;
		else
			ev <= 6'h01 << k;
		n = 0;
		do
		begin
			@(posedge pclk);
			ev <= 6'h00;
			#1;
			n++;
		end
		while (k == 6 && rp !== 1'h1 && n < 8);
		if (k == 6 && rp !== 1'h1)
		begin
			n_fail++;
			test_done();
		end
		check("restart pulse", r, rp);
		check("core reset", c, crp);
		check("restart addr", exp_addr, raddr);
		@(posedge pclk);
		mc_pin_n <= 1'h1;
		repeat (4) @(posedge pclk);
	endtask : fire

	initial
	begin
		pclk = 1'h0;
		forever #5 pclk = ~pclk;
	end

	initial
	begin
		{presetn, psel, penable, pwrite, int_hi, ev, pm, pc, paddr, pwdata} = '0;
		mc_pin_n = 1'h1;
		{n_fail, checks_done} = '0;
		rnd = 16'h0015;
		{exp_stack, exp_cfg, exp_stat, exp_addr} = '0;
		exp_cause = 8'h5C;
		exp_mask = 8'hA5;
		repeat (5) @(posedge pclk);
		presetn <= 1'h1;
		repeat (3) @(posedge pclk);
		rd_check("cause", reset_cause_pkg::CAUSE_OFF, 32'h0000005C);
		rd_check("stack", reset_cause_pkg::STACK_OFF, 32'h0);
		rd_check("config", reset_cause_pkg::CONFIG_OFF, 32'h0);
		apb(1'h1, reset_cause_pkg::SCRATCH_OFF, 32'hA5C30F96);
		apb(1'h1, reset_cause_pkg::EV_MASK_OFF, {24'h0, exp_mask});
		apb(1'h1, reset_cause_pkg::RESTART_OFF, 32'h0000FFFF);
		rd_check("restart reg", reset_cause_pkg::RESTART_OFF, 32'h0);
		apb(1'h0, 8'h1C, 32'h0);
		check("unmapped error", 32'h1, rd_err);
		check("unmapped data", 32'h0, rd_data);
		for (i = 0; i < 70; i++)
		begin
			rnd = lfsr(rnd);
			if (rnd[15:14] == 2'h0)
			begin
				apb(1'h1, reset_cause_pkg::CAUSE_OFF, {16'h0, rnd});
				exp_cause = rnd[7:0] & reset_cause_pkg::CAUSE_WMASK;
			end
			if (rnd[13])
			begin
				apb(1'h1, reset_cause_pkg::STACK_OFF, 32'h0);
				exp_stack = 8'h00;
			end
			exp_cfg = {3'h0, rnd[12:8]};
			apb(1'h1, reset_cause_pkg::CONFIG_OFF, {24'h0, exp_cfg});
			k = (i < 28) ? i / 4 : rnd[6:3] % 7;
			@(posedge pclk);
			pm <= (i < 28) ? i[1:0] : rnd[1:0];
			int_hi <= rnd[2];
			pc <= {rnd[4:0], lfsr(rnd)};
			fire(k);
			check("irq", |(exp_stat & exp_mask), irq);
			check("soft enable", exp_cause[6], sbe);
			rd_check("cause", reset_cause_pkg::CAUSE_OFF, {24'h0, exp_cause});
			rd_check("stack", reset_cause_pkg::STACK_OFF, {24'h0, exp_stack});
			rd_check("status", reset_cause_pkg::EV_STAT_OFF, {24'h0, exp_stat});
			if (rnd[7])
			begin
				apb(1'h1, reset_cause_pkg::EV_STAT_OFF, {16'h0, rnd});
				exp_stat &= ~rnd[7:0];
			end
		end
		rd_check("scratch", reset_cause_pkg::SCRATCH_OFF, 32'hA5C30F96);
		@(posedge pclk);
		presetn <= 1'h0;
		repeat (2) @(posedge pclk);
		presetn <= 1'h1;
		repeat (3) @(posedge pclk);
		rd_check("cause", reset_cause_pkg::CAUSE_OFF, 32'h0000005C);
		rd_check("restart reg", reset_cause_pkg::RESTART_OFF, 32'h0);
		rd_check("stack", reset_cause_pkg::STACK_OFF, 32'h0);
		rd_check("scratch", reset_cause_pkg::SCRATCH_OFF, 32'h0);
		check("irq", 32'h0, irq);
		check("soft enable", 32'h1, sbe);
		test_done();
	end
endmodule : tb_top
